// *** ee_params.svh ***
// constants of the two-wire eeprom read and acknowledge-poll block
`ifndef EE_PARAMS_SVH
`define EE_PARAMS_SVH

// ==========================================================================
// control byte and address layout
`define EE_TYPE_CODE   4'hA
`define EE_ADDR_W      13
`define EE_MEM_DEPTH   8192
`define EE_HI_BITS     5
`define EE_BIT_FULL    4'h8
`define EE_BIT_LAST    4'h7

// ==========================================================================
// timing: internal write cycle length in clk_sys cycles
`define EE_WR_CYCLES   20000
`define EE_CNT_W       24

`endif

// *** ee_pkg.sv ***
// types shared by the eeprom link engine and its array
package ee_pkg;

	// ======================================================================
	// link-side protocol states
	typedef enum logic [2:0] {
		EE_ST_IDLE   = 3'b000,
		EE_ST_RX     = 3'b001,
		EE_ST_ACK    = 3'b010,
		EE_ST_FETCH  = 3'b011,
		EE_ST_TX     = 3'b100,
		EE_ST_TX_ACK = 3'b101
	} ee_state_t;

	// ======================================================================
	// which byte of a command is being received
	typedef enum logic [1:0] {
		EE_K_CTRL = 2'b00,
		EE_K_AHI  = 2'b01,
		EE_K_ALO  = 2'b10,
		EE_K_DATA = 2'b11
	} ee_kind_t;

	// ======================================================================
	// array-side states
	typedef enum logic {
		EE_AR_IDLE = 1'b0,
		EE_AR_BUSY = 1'b1
	} ee_arr_state_t;

endpackage

// *** ee_mem_if.sv ***
// toggle handshake between the link engine and the memory array
`timescale 1ns/1ps
`include "ee_params.svh"

interface ee_mem_if;
	logic                   req_tgl;
	logic                   wr;
	logic [`EE_ADDR_W-1:0]  addr;
	logic [7:0]             wdata;
	logic                   ack_tgl;
	logic [7:0]             rdata;

	modport link (
		output req_tgl,
		output wr,
		output addr,
		output wdata,
		input  ack_tgl,
		input  rdata
	);

	modport array (
		input  req_tgl,
		input  wr,
		input  addr,
		input  wdata,
		output ack_tgl,
		output rdata
	);
endinterface

// *** ee_sync.sv ***
// two-flop level synchroniser, one per bit
`timescale 1ns/1ps

module ee_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] q_d;

	// ======================================================================
	// first stage feeds only the second
	always_comb begin
		meta_d = d;
		q_d    = meta_q;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= meta_d;
			q      <= q_d;
		end
	end
endmodule

// *** ee_array.sv ***
// memory array and self-timed write cycle, clk_sys domain
`timescale 1ns/1ps
`include "ee_params.svh"

module ee_array #(
	parameter int unsigned WR_CYCLES = `EE_WR_CYCLES
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	ee_mem_if.array   mem
);
	logic                  req_s;
	logic                  req_p_q, req_p_d;
	logic                  ack_tgl_q, ack_tgl_d;
	logic [7:0]            rdata_q, rdata_d;
	logic [`EE_CNT_W-1:0]  cnt_q, cnt_d;
	logic                  we;
	ee_pkg::ee_arr_state_t state_q, state_d;
	logic [7:0]            mem_q [0:`EE_MEM_DEPTH-1];

	ee_sync #(.W(1)) u_req_sync (
		.clk (clk_sys),
		.rst (rst),
		.d   (mem.req_tgl),
		.q   (req_s)
	);

	// ======================================================================
	// request decode and write timer
	always_comb begin
		req_p_d   = req_s;
		ack_tgl_d = ack_tgl_q;
		rdata_d   = rdata_q;
		cnt_d     = cnt_q;
		state_d   = state_q;
		we        = 1'b0;
		case (state_q)
			ee_pkg::EE_AR_IDLE: begin
				if (req_s != req_p_q) begin
					if (mem.wr) begin
						// ack held back until the cycle ends: link stays busy
						we      = 1'b1;
						cnt_d   = `EE_CNT_W'(WR_CYCLES - 1);
						state_d = ee_pkg::EE_AR_BUSY;
					end else begin
						rdata_d   = mem_q[mem.addr];
						ack_tgl_d = ~ack_tgl_q;
					end
				end
			end
			ee_pkg::EE_AR_BUSY: begin
				if (cnt_q == '0) begin
					ack_tgl_d = ~ack_tgl_q;
					state_d   = ee_pkg::EE_AR_IDLE;
				end else begin
					cnt_d = cnt_q - `EE_CNT_W'(1);
				end
			end
			default: state_d = ee_pkg::EE_AR_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			req_p_q   <= 1'b0;
			ack_tgl_q <= 1'b0;
			rdata_q   <= 8'h00;
			cnt_q     <= '0;
			state_q   <= ee_pkg::EE_AR_IDLE;
		end else begin
			req_p_q   <= req_p_d;
			ack_tgl_q <= ack_tgl_d;
			rdata_q   <= rdata_d;
			cnt_q     <= cnt_d;
			state_q   <= state_d;
		end
	end

	// array itself has no reset
	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem_q[mem.addr] <= mem.wdata;
		end
	end

	assign mem.ack_tgl = ack_tgl_q;
	assign mem.rdata   = rdata_q;
endmodule

// *** ee_eeprom_rd.sv ***
// two-wire eeprom target: reads, acknowledge polling, protected byte write
`timescale 1ns/1ps
`include "ee_params.svh"

// Notes on behaviour
// - no acknowledge to any control byte while a write cycle runs
// - write cycle starts at the stop; controller may poll at once
// - after write cycle the control byte is acknowledged again
// - read bit one selects read; otherwise command starts like write
// - address counter holds last accessed location plus one
// - matching read control byte acknowledged, then byte at pointer sent
// - unacknowledged byte then stop: transmission ends, line released
// - address pointer loaded before repeated start abandons the write
// - after random read counter points past the byte read
// - each controller acknowledge brings the next sequential byte
// - pointer wraps from 1FFF to 0000 on acknowledge
// - three chip-select levels compared with control byte bits
// - data changes only with clock low; else start or stop
// - data line only pulled low or released, never driven high
// - write-protect low allows reads and writes of whole range
// - write-protect high blocks array writes, reads unaffected
// - control byte is type code 1010, chip selects, read bit
// - word address high byte first, upper three bits ignored
// - write-protect sampled at the stop ending the write
module ee_eeprom_rd #(
	parameter int unsigned WR_CYCLES = `EE_WR_CYCLES
) (
	input  wire logic clk_sys,
	input  wire logic clk_link,
	input  wire logic rst,
	input  wire logic scl,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe_n,
	input  wire logic wp,
	input  wire logic chip_select_bit0,
	input  wire logic chip_select_bit1,
	input  wire logic chip_select_bit2
);
	logic [6:0]                  pin_s;
	logic                        scl_s, sda_s, wp_s, ack_s;
	logic [2:0]                  cs_s;
	logic                        scl_rise, scl_fall, start, stop, ack_edge, match;
	ee_pkg::ee_state_t           state_q, state_d;
	ee_pkg::ee_kind_t            kind_q, kind_d;
	logic [3:0]                  cnt_q, cnt_d;
	logic [7:0]                  sh_q, sh_d;
	logic [`EE_ADDR_W-1:0]       addr_q, addr_d;
	logic [`EE_HI_BITS-1:0]      ahi_q, ahi_d;
	logic [7:0]                  wdata_q, wdata_d;
	logic                        rd_mode_q, rd_mode_d, wr_pend_q, wr_pend_d;
	logic                        busy_q, busy_d, iss_q, iss_d;
	logic                        mack_q, mack_d, ack_p_q, ack_p_d;
	logic                        scl_p_q, sda_p_q, oe_n_d;
	logic                        req_tgl_q, req_tgl_d, req_wr_q, req_wr_d;
	logic [`EE_ADDR_W-1:0]       req_addr_q, req_addr_d;

	ee_mem_if mem ();
	// ======================================================================
	// pin and handshake synchronisers
	// wp pull-down lives in the pad; an open pin arrives here as low
	ee_sync #(.W(7)) u_pin_sync (
		.clk (clk_link),
		.rst (rst),
		.d   ({mem.ack_tgl, scl, sda_i, wp, chip_select_bit2, chip_select_bit1, chip_select_bit0}),
		.q   (pin_s)
	);

	ee_array #(.WR_CYCLES(WR_CYCLES)) u_array (
		.clk_sys (clk_sys),
		.rst     (rst),
		.mem     (mem.array)
	);
	assign ack_s = pin_s[6];
	assign scl_s = pin_s[5];
	assign sda_s = pin_s[4];
	assign wp_s  = pin_s[3];
	assign cs_s  = pin_s[2:0];
	assign mem.req_tgl = req_tgl_q;
	assign mem.wr      = req_wr_q;
	assign mem.addr    = req_addr_q;
	assign mem.wdata   = wdata_q;

	// ======================================================================
	// bus conditions
	assign scl_rise = scl_s & ~scl_p_q;
	assign scl_fall = ~scl_s & scl_p_q;
	assign start    = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop     = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign ack_edge = ack_s ^ ack_p_q;
	// busy hides the device from every control byte, polls included
	assign match    = (sh_q[7:4] == `EE_TYPE_CODE) && (sh_q[3:1] == cs_s)
		&& !busy_q;

	// ======================================================================
	// protocol engine
	always_comb begin
		state_d    = state_q;
		kind_d     = kind_q;
		cnt_d      = cnt_q;
		sh_d       = sh_q;
		addr_d     = addr_q;
		ahi_d      = ahi_q;
		wdata_d    = wdata_q;
		rd_mode_d  = rd_mode_q;
		wr_pend_d  = wr_pend_q;
		busy_d     = busy_q;
		iss_d      = iss_q;
		mack_d     = mack_q;
		ack_p_d    = ack_s;
		req_tgl_d  = req_tgl_q;
		req_wr_d   = req_wr_q;
		req_addr_d = req_addr_q;
		oe_n_d     = sda_oe_n;
		if (ack_edge && busy_q) begin
			busy_d = 1'b0;
		end
		if (start) begin
			// a repeated start drops the pending write, pointer stays set
			state_d   = ee_pkg::EE_ST_RX;
			kind_d    = ee_pkg::EE_K_CTRL;
			cnt_d     = 4'h0;
			rd_mode_d = 1'b0;
			wr_pend_d = 1'b0;
			oe_n_d    = 1'b1;
		end else if (stop) begin
			if (wr_pend_q) begin
				wr_pend_d = 1'b0;
				addr_d    = addr_q + `EE_ADDR_W'(1);
				if (!wp_s) begin
					req_tgl_d  = ~req_tgl_q;
					req_wr_d   = 1'b1;
					req_addr_d = addr_q;
					busy_d     = 1'b1;
				end
			end
			state_d = ee_pkg::EE_ST_IDLE;
			oe_n_d  = 1'b1;
		end else begin
			case (state_q)
				ee_pkg::EE_ST_IDLE: begin
					oe_n_d = 1'b1;
				end
				ee_pkg::EE_ST_RX: begin
					if (scl_rise && cnt_q != `EE_BIT_FULL) begin
						sh_d  = {sh_q[6:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == `EE_BIT_FULL) begin
						state_d = ee_pkg::EE_ST_ACK;
						oe_n_d  = 1'b0;
						case (kind_q)
							ee_pkg::EE_K_CTRL: begin
								if (match) begin
									rd_mode_d = sh_q[0];
									kind_d    = ee_pkg::EE_K_AHI;
								end else begin
									state_d = ee_pkg::EE_ST_IDLE;
									oe_n_d  = 1'b1;
								end
							end
							ee_pkg::EE_K_AHI: begin
								ahi_d  = sh_q[`EE_HI_BITS-1:0];
								kind_d = ee_pkg::EE_K_ALO;
							end
							ee_pkg::EE_K_ALO: begin
								addr_d = {ahi_q, sh_q};
								kind_d = ee_pkg::EE_K_DATA;
							end
							ee_pkg::EE_K_DATA: begin
								// only the last byte before stop is kept
								wdata_d   = sh_q;
								wr_pend_d = 1'b1;
							end
							default: kind_d = ee_pkg::EE_K_CTRL;
						endcase
					end
				end
				ee_pkg::EE_ST_ACK: begin
					if (scl_fall) begin
						oe_n_d = 1'b1;
						cnt_d  = 4'h0;
						iss_d  = 1'b0;
						state_d = rd_mode_q ? ee_pkg::EE_ST_FETCH : ee_pkg::EE_ST_RX;
					end
				end
				ee_pkg::EE_ST_FETCH: begin
					// fetch runs while scl is low; the controller sees no stretch
					if (!iss_q && req_tgl_q == ack_s) begin
						req_tgl_d  = ~req_tgl_q;
						req_wr_d   = 1'b0;
						req_addr_d = addr_q;
						addr_d     = addr_q + `EE_ADDR_W'(1);
						iss_d      = 1'b1;
					end else if (iss_q && ack_edge) begin
						sh_d    = mem.rdata;
						cnt_d   = 4'h0;
						oe_n_d  = mem.rdata[7];
						state_d = ee_pkg::EE_ST_TX;
					end
				end
				ee_pkg::EE_ST_TX: begin
					if (scl_fall) begin
						if (cnt_q == `EE_BIT_LAST) begin
							oe_n_d  = 1'b1;
							state_d = ee_pkg::EE_ST_TX_ACK;
						end else begin
							sh_d   = {sh_q[6:0], 1'b0};
							cnt_d  = cnt_q + 4'h1;
							oe_n_d = sh_q[6];
						end
					end
				end
				ee_pkg::EE_ST_TX_ACK: begin
					if (scl_rise) begin
						mack_d = !sda_s;
					end else if (scl_fall) begin
						iss_d   = 1'b0;
						state_d = mack_q ? ee_pkg::EE_ST_FETCH : ee_pkg::EE_ST_IDLE;
					end
				end
				default: state_d = ee_pkg::EE_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_link or posedge rst) begin
		if (rst) begin
			state_q    <= ee_pkg::EE_ST_IDLE;
			kind_q     <= ee_pkg::EE_K_CTRL;
			cnt_q      <= 4'h0;
			sh_q       <= 8'h00;
			addr_q     <= '0;
			ahi_q      <= '0;
			wdata_q    <= 8'h00;
			rd_mode_q  <= 1'b0;
			wr_pend_q  <= 1'b0;
			busy_q     <= 1'b0;
			iss_q      <= 1'b0;
			mack_q     <= 1'b0;
			ack_p_q    <= 1'b0;
			scl_p_q    <= 1'b1;
			sda_p_q    <= 1'b1;
			req_tgl_q  <= 1'b0;
			req_wr_q   <= 1'b0;
			req_addr_q <= '0;
			sda_oe_n   <= 1'b1;
			sda_o      <= 1'b0;
		end else begin
			state_q    <= state_d;
			kind_q     <= kind_d;
			cnt_q      <= cnt_d;
			sh_q       <= sh_d;
			addr_q     <= addr_d;
			ahi_q      <= ahi_d;
			wdata_q    <= wdata_d;
			rd_mode_q  <= rd_mode_d;
			wr_pend_q  <= wr_pend_d;
			busy_q     <= busy_d;
			iss_q      <= iss_d;
			mack_q     <= mack_d;
			ack_p_q    <= ack_p_d;
			scl_p_q    <= scl_s;
			sda_p_q    <= sda_s;
			req_tgl_q  <= req_tgl_d;
			req_wr_q   <= req_wr_d;
			req_addr_q <= req_addr_d;
			sda_oe_n   <= oe_n_d;
			sda_o      <= 1'b0;
		end
	end

	// ======================================================================
	// checks
	default clocking cb @(posedge clk_link); endclocking
	default disable iff (rst);
	property p_busy_nack;
		(state_q == ee_pkg::EE_ST_RX && kind_q == ee_pkg::EE_K_CTRL && scl_fall
			&& cnt_q == `EE_BIT_FULL && busy_q && !start && !stop)
			|=> (state_q == ee_pkg::EE_ST_IDLE) && sda_oe_n;
	endproperty
	a_busy_nack: assert property (p_busy_nack)
		else $error("control byte acknowledged while busy");
	property p_match_ack;
		(state_q == ee_pkg::EE_ST_RX && kind_q == ee_pkg::EE_K_CTRL && scl_fall
			&& cnt_q == `EE_BIT_FULL && match && !start && !stop)
			|=> (state_q == ee_pkg::EE_ST_ACK) && !sda_oe_n;
	endproperty
	a_match_ack: assert property (p_match_ack)
		else $error("matching control byte not acknowledged");
	property p_wr_at_stop;
		(stop && wr_pend_q && !wp_s) |=> busy_q && (req_tgl_q != $past(req_tgl_q)) && req_wr_q;
	endproperty
	a_wr_at_stop: assert property (p_wr_at_stop)
		else $error("write cycle not started at stop");
	property p_wp_block;
		(stop && wr_pend_q && wp_s && !busy_q) |=> !busy_q && $stable(req_tgl_q);
	endproperty
	a_wp_block: assert property (p_wp_block)
		else $error("write issued while protected");
	property p_drive_scl_low;
		$fell(sda_oe_n) |-> !$past(scl_s);
	endproperty
	a_drive_scl_low: assert property (p_drive_scl_low)
		else $error("data line pulled while clock high");
	property p_open_drain;
		!sda_o;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("data line driven high");
	property p_ptr_inc;
		(state_q == ee_pkg::EE_ST_FETCH && !iss_q && req_tgl_q == ack_s && !start && !stop)
			|=> (addr_q == $past(addr_q) + `EE_ADDR_W'(1)) && (req_addr_q == $past(addr_q));
	endproperty
	a_ptr_inc: assert property (p_ptr_inc)
		else $error("pointer not advanced on fetch");
	property p_seq_next;
		(state_q == ee_pkg::EE_ST_TX_ACK && scl_fall && mack_q && !start && !stop)
			|=> state_q == ee_pkg::EE_ST_FETCH ##1 (addr_q == $past(addr_q, 2) + `EE_ADDR_W'(1));
	endproperty
	a_seq_next: assert property (p_seq_next)
		else $error("acknowledged byte not followed by fetch");
	property p_nack_release;
		(state_q == ee_pkg::EE_ST_TX_ACK && scl_fall && !mack_q && !start)
			|=> (state_q == ee_pkg::EE_ST_IDLE && sda_oe_n) [*2];
	endproperty
	a_nack_release: assert property (p_nack_release)
		else $error("line not released after missing acknowledge");
	property p_restart_drop;
		start |=> !wr_pend_q && state_q == ee_pkg::EE_ST_RX && sda_oe_n;
	endproperty
	a_restart_drop: assert property (p_restart_drop)
		else $error("pending write survived a start");
endmodule

// *** ee_bus_ctl.sv ***
// behavioural two-wire bus controller facing the eeprom
`timescale 1ns/1ps

module ee_bus_ctl (
	input  wire logic clk_sys,
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda
);
	// ======================================================================
	// idle bus: clock high and still, data released to the pull-up
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// each phase spans many link cycles so the synchronisers keep up
	task automatic ph(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// ======================================================================
	// start or repeated start; data released while scl is low, then pulled low while scl is high
	task automatic start();
		sda_pull = 1'b0;
		ph(60);
		scl = 1'b1;
		ph(60);
		sda_pull = 1'b1;
		ph(60);
		scl = 1'b0;
		ph(16);
	endtask

	task automatic stop();
		sda_pull = 1'b1;
		ph(60);
		scl = 1'b1;
		ph(60);
		sda_pull = 1'b0;
		ph(60);
	endtask

	// ======================================================================
	// one bit: set while low, sample at the end of the high phase
	task automatic bit_io(input logic b, output logic r);
		sda_pull = ~b;
		ph(60);
		scl = 1'b1;
		ph(60);
		r = sda;
		scl = 1'b0;
		ph(16);
	endtask

	// msb first, ninth clock reads the target's acknowledge
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	// acknowledge asks for more; withheld acknowledge ends the read
	task automatic recv_byte(input logic give_ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(~give_ack, r);
	endtask
endmodule

// *** ee_eeprom_rd_tb.sv ***
// self-checking bench for the two-wire eeprom read and poll engine
`timescale 1ns/1ps

module ee_eeprom_rd_tb;
	// long enough that the first poll lands inside the write cycle
	localparam int unsigned WR_N = 2500;
	logic       clk_sys;
	logic       clk_link;
	logic       rst;
	logic       wp;
	logic [2:0] cs_pins;
	logic       scl;
	logic       sda_pull;
	logic       sda_o;
	logic       sda_oe_n;
	wire        sda_wire;
	int         err_total;
	int         n_tests;
	int         cyc;

	// open drain wire with pull-up
	assign sda_wire = ~(sda_pull | ~sda_oe_n);

	ee_eeprom_rd #(.WR_CYCLES(WR_N)) dut (
		.clk_sys          (clk_sys),
		.clk_link         (clk_link),
		.rst              (rst),
		.scl              (scl),
		.sda_i            (sda_wire),
		.sda_o            (sda_o),
		.sda_oe_n         (sda_oe_n),
		.wp               (wp),
		.chip_select_bit0 (cs_pins[0]),
		.chip_select_bit1 (cs_pins[1]),
		.chip_select_bit2 (cs_pins[2])
	);

	ee_bus_ctl u_ctl (
		.clk_sys  (clk_sys),
		.scl      (scl),
		.sda_pull (sda_pull),
		.sda      (sda_wire)
	);

	// ======================================================================
	// clocks, watchdog, checks
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	initial begin
		clk_link = 1'b0;
		#3.7;
		forever #16 clk_link = ~clk_link;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			close_out();
		end
	end

	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// the device may only pull low; looked at away from the edge that updates it
	always @(negedge clk_link) begin
		if (rst === 1'b0 && sda_oe_n === 1'b0) begin
			chk_bit("sda_o", 1'b0, sda_o);
		end
	end

	// ======================================================================
	// command helpers
	task automatic ctrl(input logic rw, output logic ack);
		u_ctl.send_byte({4'hA, cs_pins, rw}, ack);
	endtask

	task automatic set_ptr(input logic [15:0] a);
		logic ack;
		u_ctl.start();
		ctrl(1'b0, ack);
		chk_bit("write ctrl ack", 1'b1, ack);
		u_ctl.send_byte(a[15:8], ack);
		chk_bit("addr hi ack", 1'b1, ack);
		u_ctl.send_byte(a[7:0], ack);
		chk_bit("addr lo ack", 1'b1, ack);
	endtask

	task automatic rd_open();
		logic ack;
		u_ctl.start();
		ctrl(1'b1, ack);
		chk_bit("read ctrl ack", 1'b1, ack);
	endtask

	// wp flips right after the stop; only its level at the stop counts
	task automatic wr_byte(input logic [15:0] a, input logic [7:0] d, input logic prot);
		logic ack;
		wp = 1'b0;
		set_ptr(a);
		u_ctl.send_byte(d, ack);
		chk_bit("data ack", 1'b1, ack);
		wp = prot;
		u_ctl.stop();
		wp = ~prot;
	endtask

	task automatic poll(input logic exp_busy);
		int   tries;
		logic ack;
		tries = 0;
		ack = 1'b0;
		while (!ack && tries < 5) begin
			u_ctl.start();
			ctrl(1'b0, ack);
			tries++;
		end
		u_ctl.stop();
		chk_bit("poll acked", 1'b1, ack);
		chk_bit("poll refused while busy", exp_busy, tries > 1);
	endtask

	// ======================================================================
	// scenarios
	task automatic t_write_poll();
		wr_byte(16'hFFFF, 8'h5A, 1'b0);
		poll(1'b1);
		wr_byte(16'hE000, 8'hC3, 1'b0);
		poll(1'b1);
		wr_byte(16'h0001, 8'h96, 1'b0);
		poll(1'b1);
	endtask

	task automatic t_seq_wrap();
		logic [7:0] d;
		set_ptr(16'h1FFF);
		rd_open();
		u_ctl.recv_byte(1'b1, d);
		chk_byte("byte at top", 8'h5A, d);
		u_ctl.recv_byte(1'b0, d);
		chk_byte("byte after wrap", 8'hC3, d);
		u_ctl.stop();
		chk_bit("released after stop", 1'b1, sda_oe_n);
		rd_open();
		u_ctl.recv_byte(1'b0, d);
		chk_byte("current address read", 8'h96, d);
		u_ctl.stop();
		chk_bit("released after read", 1'b1, sda_oe_n);
	endtask

	task automatic t_protect();
		logic [7:0] d;
		wr_byte(16'h0000, 8'h11, 1'b1);
		poll(1'b0);
		set_ptr(16'h0000);
		rd_open();
		u_ctl.recv_byte(1'b0, d);
		chk_byte("protected byte kept", 8'hC3, d);
		u_ctl.stop();
	endtask

	task automatic t_select();
		logic [7:0] bad [4];
		logic [7:0] d;
		logic       ack;
		bad = '{8'hA9, 8'hA3, 8'hAF, 8'hBB};
		for (int i = 0; i < 4; i++) begin
			u_ctl.start();
			u_ctl.send_byte(bad[i], ack);
			chk_bit("foreign ctrl refused", 1'b0, ack);
			u_ctl.recv_byte(1'b0, d);
			chk_byte("line left released", 8'hFF, d);
			u_ctl.stop();
		end
		// asymmetric straps, so a swapped chip-select bit order is caught
		cs_pins = 3'h6;
		rd_open();
		u_ctl.recv_byte(1'b0, d);
		chk_byte("read with new straps", 8'h96, d);
		u_ctl.stop();
	endtask

	// ======================================================================
	// main sequence
	initial begin
		rst = 1'b1;
		wp = 1'b0;
		cs_pins = 3'h5;
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		repeat (12) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		chk_bit("released at reset", 1'b1, sda_oe_n);
		repeat (60) @(posedge clk_sys);
		#1;
		t_write_poll();
		t_seq_wrap();
		t_protect();
		t_select();
		close_out();
	end
endmodule
